// File: rtl/rcfg_pkg.sv
package rcfg_pkg;
  // register offsets of the lane three pair
  localparam logic [7:0] IDLE_FAR_RECEIVER_DETECT_MODE_OFS = 8'h23;
  localparam logic [7:0] EQ_OFS = 8'h24;
  localparam logic [7:0] SWING_OFS = 8'h25;
  localparam logic [7:0] DEEMPH_OFS = 8'h26;
  // reset values
  localparam logic [7:0] IDLE_FAR_RECEIVER_DETECT_MODE_RST = 8'h00;
  localparam logic [7:0] EQ_RST = 8'h2F;
  localparam logic [7:0] SWING_RST = 8'hAD;
  localparam logic [7:0] DEEMPH_RST = 8'h02;
  // field positions
  localparam int IDLE_AUTO_BIT = 5;
  localparam int IDLE_SEL_BIT = 4;
  localparam int FAR_RECEIVER_DETECT_MODE_LSB = 2;
  localparam int SCP_BIT = 7;
  localparam int GEN_SEL_BIT = 6;
  localparam int DEEMPH_W = 5;
  localparam int RATE_W = 2;
  // receiver-detect field codes
  typedef enum logic [1:0] {
    RXD_HIZ = 2'b00,
    RXD_AUTO_LIMITED = 2'b01,
    RXD_AUTO_ENDLESS = 2'b10,
    RXD_FORCE_50 = 2'b11
  } rcfg_far_receiver_detect_mode_t;
  // detection timing: 12 ms between probes, 50 probes in limited mode
  localparam int unsigned DETECT_PERIOD_MS = 12;
  localparam int unsigned CLOCK_KHZ = 100000;
  localparam int unsigned DETECT_CYCLES = DETECT_PERIOD_MS * CLOCK_KHZ;
  localparam logic [5:0] MAX_ATTEMPTS = 6'h32;
  // two-wire slave states
  typedef enum logic [2:0] {
    SMB_IDLE = 3'b000,
    SMB_ADDR = 3'b001,
    SMB_REG = 3'b010,
    SMB_WDATA = 3'b011,
    SMB_RDATA = 3'b100,
    SMB_SKIP = 3'b101
  } rcfg_smb_t;
  // positions in the pin synchroniser vector
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_SIGDET = 2;
  localparam int SY_SENSE = 3;
  localparam int SY_AUTO = 4;
  localparam int SY_RATE = 5;
  localparam int SY_IDLE = 7;
  localparam int SY_RXD = 8;
  localparam int SY_GEN = 10;
  localparam int SY_W = 11;
endpackage : rcfg_pkg

// File: rtl/rcfg_lane_regs.sv
`timescale 1ns/100ps
// What this block does
// - bit 5 set: automatic idle detection drives mute; clear: bit 4 decides
// - manual idle: bit 4 one mutes the output, zero keeps it active
// - written idle bits override the idle pin level
// - detect field 00 keeps input termination high impedance
// - field 01 probes every 12 ms, stops after 50 failed probes
// - field 10 probes every 12 ms until a receiver is found
// - auto modes: high impedance until found, then 50 ohm termination
// - field 11 forces 50 ohm; written field overrides detect pin
// - eight-bit equalizer level, 256 steps, reset 0x2F
// - swing register bit 7 enables short-circuit protection
// - swing bit 6 one selects gen 1/2, zero gen 3 transparent mode
// - written generation bit overrides the mode pin
// - three-bit swing code 000..111 selects 0.7..1.4 V, default 101
// - status bit 7 reads one once a far receiver is found
// - status bits 6:5 report detected link rate
// - rate status meaningful only with mode pin automatic
// - three-bit de-emphasis code, default 010
module rcfg_lane_regs #(
  parameter logic [6:0] smb_addr = 7'h2A, // arbitrary slave address
  parameter int unsigned detect_interval = rcfg_pkg::DETECT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // two-wire management pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // configuration pins
  input wire logic idle_pin_mute,
  input wire logic [1:0] far_receiver_detect_mode_pin,
  input wire logic mode_pin_gen12,
  input wire logic mode_pin_auto,
  // analog lane status
  input wire logic signal_present,
  input wire logic far_receiver_sense,
  input wire logic [rcfg_pkg::RATE_W-1:0] detected_rate_in,
  // lane controls
  output logic output_mute,
  output logic input_term_50,
  output logic rx_detect_probe,
  output logic gen12_select,
  output logic short_protect_en,
  output logic [2:0] output_swing_level,
  output logic [2:0] output_deemphasis_level,
  output logic [7:0] input_boost_level
);
  import rcfg_pkg::*;

  typedef struct packed {
    logic [SY_W-1:0] sync1, sync2;
    logic scl_prev, sda_prev;
    rcfg_smb_t st;
    logic [3:0] bitcnt;
    logic [7:0] sh, ptr;
    logic rw, mack, sda_drive;
    logic [7:0] idle_far_receiver_detect_mode, eq, swing;
    logic [DEEMPH_W-1:0] deemph;
    logic ovr_idle, ovr_far_receiver_detect_mode, ovr_mode;
    rcfg_far_receiver_detect_mode_t last_code;
    logic found;
    logic [31:0] tmr;
    logic [5:0] attempts;
    logic probe, mute, term_50, gen12;
  } rcfg_state_t;
  localparam rcfg_state_t RST_STATE = '{
    sync1: SY_W'(2'b11), sync2: SY_W'(2'b11), scl_prev: 1'b1, sda_prev: 1'b1, // bus idles high, no false edge
    st: SMB_IDLE,
    last_code: RXD_HIZ,
    idle_far_receiver_detect_mode: IDLE_FAR_RECEIVER_DETECT_MODE_RST,
    eq: EQ_RST,
    swing: SWING_RST,
    deemph: DEEMPH_RST[DEEMPH_W-1:0],
    default: '0
  };
  rcfg_state_t s;
  rcfg_state_t next_s;
  logic scl, sda, scl_rise, scl_fall, start_cond, stop_cond, sense, auto_mode, limit_hit;
  logic [1:0] rate_shown;
  logic [7:0] rd_data;
  rcfg_far_receiver_detect_mode_t code;

  //////////////////////////////////////////////////////////////////////
  // pin views, all taken from the second synchroniser stage
  assign scl = s.sync2[SY_SCL];
  assign sda = s.sync2[SY_SDA];
  assign sense = s.sync2[SY_SENSE];
  assign scl_rise = scl & ~s.scl_prev;
  assign scl_fall = ~scl & s.scl_prev;
  // start and stop need scl high over both samples
  assign start_cond = scl & s.scl_prev & s.sda_prev & ~sda;
  assign stop_cond = scl & s.scl_prev & ~s.sda_prev & sda;
  // rate is forced to 00 when the pin is not automatic
  assign rate_shown = s.sync2[SY_AUTO] ? s.sync2[SY_RATE +: RATE_W] : 2'h0;
  // written field wins over the detect pin
  assign code = s.ovr_far_receiver_detect_mode ? rcfg_far_receiver_detect_mode_t'(s.idle_far_receiver_detect_mode[FAR_RECEIVER_DETECT_MODE_LSB +: 2])
                            : rcfg_far_receiver_detect_mode_t'(s.sync2[SY_RXD +: 2]);
  assign auto_mode = (code == RXD_AUTO_LIMITED) || (code == RXD_AUTO_ENDLESS);
  assign limit_hit = (code == RXD_AUTO_LIMITED) && (s.attempts == MAX_ATTEMPTS);

  // read mux; unmapped offsets read zero
  always_comb
  begin
    unique case (s.ptr)
      IDLE_FAR_RECEIVER_DETECT_MODE_OFS: rd_data = s.idle_far_receiver_detect_mode;
      EQ_OFS: rd_data = s.eq;
      SWING_OFS: rd_data = s.swing;
      DEEMPH_OFS: rd_data = {s.found, rate_shown, s.deemph};
      default: rd_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // next state: slave engine, register writes, detection, lane controls
  always_comb
  begin
    next_s = s;
    next_s.sync1 = {mode_pin_gen12, far_receiver_detect_mode_pin, idle_pin_mute, detected_rate_in,
                    mode_pin_auto, far_receiver_sense, signal_present, sda_in, scl_in};
    next_s.sync2 = s.sync1;
    next_s.scl_prev = scl;
    next_s.sda_prev = sda;
    next_s.probe = 1'b0;
    // bus engine; a start or stop aborts whatever is in flight
    if (start_cond)
    begin
      next_s.st = SMB_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.sda_drive = 1'b0;
    end
    else if (stop_cond)
    begin
      next_s.st = SMB_IDLE;
      next_s.sda_drive = 1'b0;
    end
    else if (s.st != SMB_IDLE && scl_rise)
    begin
      if (s.bitcnt < 4'h8)
      begin
        if (s.st != SMB_RDATA)
          next_s.sh = {s.sh[6:0], sda};
      end
      else
        next_s.mack = ~sda;
      next_s.bitcnt = s.bitcnt + 4'h1;
    end
    else if (s.st != SMB_IDLE && scl_fall)
    begin
      if (s.bitcnt == 4'h8)
      begin
        // acknowledge slot opens
        next_s.sda_drive = 1'b0;
        unique case (s.st)
          SMB_ADDR:
          begin
            next_s.rw = s.sh[0];
            next_s.sda_drive = (s.sh[7:1] == smb_addr);
          end
          SMB_REG:
          begin
            next_s.ptr = s.sh;
            next_s.sda_drive = 1'b1;
          end
          SMB_WDATA:
          begin
            next_s.sda_drive = 1'b1;
            // single byte lands at the pointer
            unique case (s.ptr)
              IDLE_FAR_RECEIVER_DETECT_MODE_OFS:
              begin
                next_s.idle_far_receiver_detect_mode = s.sh;
                next_s.ovr_idle = 1'b1;
                next_s.ovr_far_receiver_detect_mode = 1'b1;
              end
              EQ_OFS: next_s.eq = s.sh;
              SWING_OFS:
              begin
                next_s.swing = s.sh;
                next_s.ovr_mode = 1'b1;
              end
              // status bits 7:5 are not stored, so writes to them vanish
              DEEMPH_OFS: next_s.deemph = s.sh[DEEMPH_W-1:0];
              default: ;
            endcase
          end
          default: ;
        endcase
      end
      else if (s.bitcnt == 4'h9)
      begin
        // acknowledge slot closes
        next_s.bitcnt = 4'h0;
        next_s.sda_drive = 1'b0;
        unique case (s.st)
          SMB_ADDR:
          begin
            if (!s.sda_drive)
              next_s.st = SMB_SKIP;
            else if (s.rw)
            begin
              next_s.st = SMB_RDATA;
              next_s.sh = rd_data;
              next_s.ptr = s.ptr + 8'h01;
              next_s.sda_drive = ~rd_data[7];
            end
            else
              next_s.st = SMB_REG;
          end
          SMB_REG: next_s.st = SMB_WDATA;
          SMB_WDATA: next_s.ptr = s.ptr + 8'h01;
          SMB_RDATA:
          begin
            if (s.mack)
            begin
              next_s.sh = rd_data;
              next_s.ptr = s.ptr + 8'h01;
              next_s.sda_drive = ~rd_data[7];
            end
            else
              next_s.st = SMB_SKIP;
          end
          default: ;
        endcase
      end
      else if (s.st == SMB_RDATA && s.bitcnt != 4'h0)
      begin
        // open-drain: pull low only for zero bits
        next_s.sh = {s.sh[6:0], 1'b0};
        next_s.sda_drive = ~s.sh[6];
      end
    end
    // far receiver detection
    next_s.last_code = code;
    if (code != s.last_code || code == RXD_HIZ)
    begin
      // a new mode restarts the probe schedule
      next_s.tmr = 32'h0;
      next_s.attempts = 6'h00;
      if (code == RXD_HIZ)
        next_s.found = 1'b0;
    end
    else if (auto_mode && !s.found && !limit_hit)
    begin
      if (s.tmr == detect_interval - 32'h1)
      begin
        next_s.tmr = 32'h0;
        next_s.probe = 1'b1;
        if (s.attempts != MAX_ATTEMPTS)
          next_s.attempts = s.attempts + 6'h01;
        if (sense)
          next_s.found = 1'b1;
      end
      else
        next_s.tmr = s.tmr + 32'h1;
    end
    // termination: hi-z unless forced or found in auto modes
    next_s.term_50 = (code == RXD_FORCE_50) || (auto_mode && s.found);
    // idle mute: pin level until the register is written
    if (s.ovr_idle)
      next_s.mute = s.idle_far_receiver_detect_mode[IDLE_AUTO_BIT] ? ~s.sync2[SY_SIGDET]
                                                : s.idle_far_receiver_detect_mode[IDLE_SEL_BIT];
    else
      next_s.mute = s.sync2[SY_IDLE];
    next_s.gen12 = s.ovr_mode ? s.swing[GEN_SEL_BIT] : s.sync2[SY_GEN];
  end

  // single state register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      s <= RST_STATE;
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all but the tied-low sda_out from flops
  assign sda_out = 1'b0;
  assign sda_oe_n = ~s.sda_drive;
  assign output_mute = s.mute;
  assign input_term_50 = s.term_50;
  assign rx_detect_probe = s.probe;
  assign gen12_select = s.gen12;
  assign short_protect_en = s.swing[SCP_BIT];
  assign output_swing_level = s.swing[2:0];
  assign output_deemphasis_level = s.deemph[2:0];
  assign input_boost_level = s.eq;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  chk_auto_idle_mute: assert property (
    s.ovr_idle && s.idle_far_receiver_detect_mode[IDLE_AUTO_BIT] |=> output_mute == !$past(s.sync2[SY_SIGDET]))
    else $error("auto idle mute mismatch");
  chk_manual_idle_sel: assert property (
    s.ovr_idle && !s.idle_far_receiver_detect_mode[IDLE_AUTO_BIT] |=> output_mute == $past(s.idle_far_receiver_detect_mode[IDLE_SEL_BIT]))
    else $error("manual idle mute mismatch");
  chk_pin_idle_used: assert property (
    !s.ovr_idle |=> output_mute == $past(s.sync2[SY_IDLE]))
    else $error("idle pin not followed");
  chk_hiz_term: assert property (
    code == RXD_HIZ |=> !input_term_50)
    else $error("termination not hi-z");
  chk_probe_limit: assert property (
    limit_hit |=> !rx_detect_probe [*2])
    else $error("probe after attempt limit");
  chk_endless_timer: assert property (
    code == RXD_AUTO_ENDLESS && $past(code) == RXD_AUTO_ENDLESS && !s.found && s.attempts == MAX_ATTEMPTS
    |=> s.tmr != $past(s.tmr))
    else $error("endless detect stalled");
  chk_auto_term: assert property (
    auto_mode |=> input_term_50 == $past(s.found))
    else $error("auto termination mismatch");
  chk_forced_term: assert property (
    code == RXD_FORCE_50 |=> input_term_50)
    else $error("forced termination missing");
  chk_gen_override: assert property (
    s.ovr_mode |=> gen12_select == $past(s.swing[GEN_SEL_BIT]))
    else $error("generation select not from register");
  chk_rate_gate: assert property (
    s.ptr == DEEMPH_OFS && !s.sync2[SY_AUTO] |-> rd_data[6:5] == 2'h0)
    else $error("rate shown without automatic mode");
  chk_status_kept: assert property (
    $past(s.found) && code == $past(code) && code != RXD_HIZ |-> s.found)
    else $error("detect status lost");

  cov_probe: cover property (rx_detect_probe);
  cov_found: cover property ($rose(s.found));
  cov_write_swing: cover property (s.ovr_mode && !$past(s.ovr_mode));
  cov_read_byte: cover property (s.st == SMB_RDATA && s.mack && scl_fall && s.bitcnt == 4'h9);
endmodule : rcfg_lane_regs

// File: bench/rcfg_host_model.sv
`timescale 1ns/100ps
// two-wire management host; the line has a pull-up, so released means high
module rcfg_host_model #(
  parameter logic [6:0] addr = 7'h2A // arbitrary slave address
) (
  // clock
  input wire logic clock,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // six clocks a phase, above the four the slave needs to see a level
  localparam int HALF = 6;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clk
  // data changes only while the clock is low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic got);
    @(posedge clock);
    sda <= b;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    got = sda_line;
    scl <= 1'b0;
  endtask : bit_io
  // also serves as repeated start from a low clock
  task automatic start_cond();
    @(posedge clock);
    sda <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda <= 1'b0;
    wait_clk(HALF);
    scl <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    @(posedge clock);
    sda <= 1'b0;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda <= 1'b1;
    wait_clk(HALF);
  endtask : stop_cond
  // msb first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask : byte_io
  // one byte at one offset per transfer
  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    byte_io(ofs, 1'b1, rx, a1);
    byte_io(d, 1'b1, rx, a2);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask : wr_reg
  // pointer set by a write, then repeated start and one byte with nack
  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    byte_io(ofs, 1'b1, rx, a1);
    start_cond();
    byte_io({addr, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b1, d, a3);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask : rd_reg
  // burst read: master ack after the first byte, nack after the second
  task automatic rd_pair(input logic [7:0] ofs, output logic [15:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3, a4;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    byte_io(ofs, 1'b1, rx, a1);
    start_cond();
    byte_io({addr, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b0, d[15:8], a3);
    byte_io(8'hFF, 1'b1, d[7:0], a4);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask : rd_pair
endmodule : rcfg_host_model

// File: bench/test_repeater_channel_cfg_regs.sv
`timescale 1ns/100ps
module test_repeater_channel_cfg_regs;
  import rcfg_pkg::*;
  // short probe interval keeps the fifty-probe run near a thousand cycles
  localparam int unsigned INTERVAL = 20;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic scl, host_sda, sda_line, sda_out, sda_oe_n;
  logic idle_pin_mute = 1'b1;
  logic [1:0] far_receiver_detect_mode_pin = 2'b11;
  logic mode_pin_gen12 = 1'b0;
  logic mode_pin_auto = 1'b0;
  logic signal_present = 1'b1;
  logic far_receiver_sense = 1'b0;
  logic [1:0] detected_rate_in = 2'b00;
  logic output_mute, input_term_50, rx_detect_probe, gen12_select, short_protect_en;
  logic [2:0] output_swing_level, output_deemphasis_level;
  logic [7:0] input_boost_level;
  int mismatches = 0;
  int comparisons = 0;
  int probes = 0;
  int cycles = 0;
  int p0;
  logic [31:0] seed = 32'h32AE;
  logic [7:0] v;
  logic [15:0] pair;
  logic pair_ok;
  ////////////////////////////////////////////////////////////
  always #5 clock = ~clock;
  // wired-and of host and slave on the pulled-up data line
  assign sda_line = host_sda & (sda_oe_n | sda_out);
  rcfg_lane_regs #(.smb_addr(7'h2A), .detect_interval(INTERVAL)) rcfg_lane_regs_i (.clock(clock),
    .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .idle_pin_mute(idle_pin_mute), .far_receiver_detect_mode_pin(far_receiver_detect_mode_pin), .mode_pin_gen12(mode_pin_gen12),
    .mode_pin_auto(mode_pin_auto), .signal_present(signal_present), .far_receiver_sense(far_receiver_sense),
    .detected_rate_in(detected_rate_in), .output_mute(output_mute), .input_term_50(input_term_50),
    .rx_detect_probe(rx_detect_probe), .gen12_select(gen12_select), .short_protect_en(short_protect_en),
    .output_swing_level(output_swing_level), .output_deemphasis_level(output_deemphasis_level),
    .input_boost_level(input_boost_level));
  rcfg_host_model #(.addr(7'h2A)) rcfg_host_model_i (.clock(clock), .sda_line(sda_line), .scl(scl),
    .sda(host_sda));
  // probe pulses are counted here only; scenarios take snapshots
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (rx_detect_probe === 1'b1)
      probes <= probes + 1;
    if (cycles == 60000)
    begin
      mismatches++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    rcfg_host_model_i.wr_reg(ofs, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask : wr
  task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] got;
    logic ok;
    rcfg_host_model_i.rd_reg(ofs, got, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk($sformatf("register %h", ofs), exp, got);
  endtask : rdc
  // pins pass two sync stages and an output stage
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask : settle
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    settle();
    // defaults, with the pins still in charge
    chk("boost", EQ_RST, input_boost_level);
    chk("swing", 8'h05, {5'h00, output_swing_level});
    chk("deemph", 8'h02, {5'h00, output_deemphasis_level});
    chk("protect", 8'h01, {7'h00, short_protect_en});
    chk("pin mute", 8'h01, {7'h00, output_mute});
    chk("pin term", 8'h01, {7'h00, input_term_50});
    rdc(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, IDLE_FAR_RECEIVER_DETECT_MODE_RST);
    rdc(EQ_OFS, EQ_RST);
    rdc(SWING_OFS, SWING_RST);
    rdc(DEEMPH_OFS, DEEMPH_RST);
    // equalizer: both ends of the range, then random levels
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
      wr(EQ_OFS, v);
      chk("boost out", v, input_boost_level);
      rdc(EQ_OFS, v);
    end
    // every swing code; mode pin always opposes the written bit
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      v = {seed[7:6], 3'b101, i[2:0]};
      mode_pin_gen12 <= ~v[6];
      wr(SWING_OFS, v);
      settle();
      chk("gen", {7'h00, v[6]}, {7'h00, gen12_select});
      chk("protect", {7'h00, v[7]}, {7'h00, short_protect_en});
      chk("swing", {5'h00, v[2:0]}, {5'h00, output_swing_level});
    end
    rdc(SWING_OFS, v);
    // burst read: the master ack walks the pointer from swing to the status byte
    rcfg_host_model_i.rd_pair(SWING_OFS, pair, pair_ok);
    chk("pair ack", 8'h01, {7'h00, pair_ok});
    chk("pair swing", v, pair[15:8]);
    chk("pair status", DEEMPH_RST, pair[7:0]);
    // every de-emphasis code; status bits ignore the written ones
    for (int i = 0; i < 8; i++)
    begin
      wr(DEEMPH_OFS, {3'b111, 2'b00, i[2:0]});
      chk("deemph", {5'h00, i[2:0]}, {5'h00, output_deemphasis_level});
    end
    detected_rate_in <= 2'b11;
    settle();
    rdc(DEEMPH_OFS, 8'h07);
    mode_pin_auto <= 1'b1;
    settle();
    rdc(DEEMPH_OFS, 8'h67);
    detected_rate_in <= 2'b01;
    settle();
    rdc(DEEMPH_OFS, 8'h27);
    // idle: register overrides the pin, manual then automatic
    idle_pin_mute <= 1'b0;
    wr(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, 8'h10);
    chk("manual mute", 8'h01, {7'h00, output_mute});
    idle_pin_mute <= 1'b1;
    wr(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, 8'h00);
    settle();
    chk("manual on", 8'h00, {7'h00, output_mute});
    chk("hiz term", 8'h00, {7'h00, input_term_50});
    wr(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, 8'h20);
    signal_present <= 1'b0;
    settle();
    chk("auto mute", 8'h01, {7'h00, output_mute});
    signal_present <= 1'b1;
    settle();
    chk("auto on", 8'h00, {7'h00, output_mute});
    // forced termination stays when the pin changes
    wr(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, 8'h0C);
    far_receiver_detect_mode_pin <= 2'b00;
    settle();
    chk("forced term", 8'h01, {7'h00, input_term_50});
    // limited detection gives up after fifty probes
    p0 = probes;
    wr(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, 8'h04);
    repeat (50 * INTERVAL + 200) @(posedge clock);
    chk("limited probes", 8'd50, 8'(probes - p0));
    chk("limited term", 8'h00, {7'h00, input_term_50});
    // endless detection keeps probing until found
    p0 = probes;
    wr(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, 8'h08);
    repeat (1200) @(posedge clock);
    chk("endless probes", 8'h01, {7'h00, (probes - p0) > 55});
    chk("endless term", 8'h00, {7'h00, input_term_50});
    far_receiver_sense <= 1'b1;
    repeat (INTERVAL + 10) @(posedge clock);
    chk("found term", 8'h01, {7'h00, input_term_50});
    p0 = probes;
    repeat (3 * INTERVAL) @(posedge clock);
    chk("probes after find", 8'h00, 8'(probes - p0));
    rdc(DEEMPH_OFS, 8'hA7);
    wr(IDLE_FAR_RECEIVER_DETECT_MODE_OFS, 8'h00);
    rdc(DEEMPH_OFS, 8'h27);
    // unmapped offset: acked, discarded, reads zero
    wr(8'h30, 8'h5A);
    rdc(8'h30, 8'h00);
    results();
  end
endmodule : test_repeater_channel_cfg_regs
